// *** itc_defs.svh ***
// Purpose: shared constants of the interrupt transfer controller
// Assumes: included by bare name from the package and the design modules
// Notes: byte addresses on the register bus, one 32-bit word per register
`ifndef ITC_DEFS_SVH
`define ITC_DEFS_SVH
// ==========================================================
// sizes
`define ITC_NSRC 8
`define ITC_NCH 8
`define ITC_IDX_W 3
`define ITC_PRIO_W 4
`define ITC_CNT_W 8
`define ITC_CTL_W 4
`define ITC_PTR_W 16
`define ITC_ADDR_W 8
// ==========================================================
// register offsets (bytes)
`define ITC_OFS_SRC 8'h00
`define ITC_OFS_CNT 8'h20
`define ITC_OFS_SRCP 8'h40
`define ITC_OFS_DSTP 8'h60
`define ITC_OFS_STAT 8'h80
`define ITC_OFS_MASK 8'h84
`define ITC_OFS_STATE 8'h88
// ==========================================================
// source control fields
`define ITC_SC_REQ 0
`define ITC_SC_EN 1
`define ITC_SC_PRIO_LO 2
`define ITC_SC_CHSVC 6
`define ITC_SC_CH_LO 7
// channel register: count in the low byte, control above it
`define ITC_CTL_LO 8
`define ITC_CTL_WORD 0
`define ITC_CTL_INCS 1
`define ITC_CTL_INCD 2
`define ITC_CTL_CONT 3
// engine state readback
`define ITC_STV_LO 8
`define ITC_STP_LO 12
// ==========================================================
// state bit positions (one-hot)
`define ITC_SB_IDLE 0
`define ITC_SB_XFER 1
`define ITC_SB_REQ 2
`define ITC_SB_PUSH 3
`define ITC_SB_BRANCH 4
`define ITC_ST_W 5
// ==========================================================
// reset values and pointer steps
`define ITC_RST_CNT 8'h00
`define ITC_RST_PTR 16'h0000
`define ITC_STEP_BYTE 16'h0001
`define ITC_STEP_WORD 16'h0002
`define ITC_CNT_LAST 8'h01
`endif

// *** itc_pkg.sv ***
// Purpose: types of the interrupt transfer controller
// Assumes: itc_defs.svh holds the sizes and field positions; the state codes are set here
// Notes: states are one-hot
`include "itc_defs.svh"
package itc_pkg;
   // ==========================================================
   // scalar types
   typedef logic [`ITC_IDX_W-1:0] itc_idx_t;
   typedef logic [`ITC_PRIO_W-1:0] itc_prio_t;
   typedef logic [`ITC_CNT_W-1:0] itc_cnt_t;
   typedef logic [`ITC_CTL_W-1:0] itc_ctl_t;
   typedef logic [`ITC_PTR_W-1:0] itc_ptr_t;
   // ==========================================================
   // engine sequencer states
   typedef enum logic [`ITC_ST_W-1:0] {
      ST_IDLE = 5'h01,
      ST_XFER = 5'h02,
      ST_REQ = 5'h04,
      ST_PUSH = 5'h08,
      ST_BRANCH = 5'h10
   } itc_state_t;
endpackage

// *** itc_arb.sv ***
// Purpose: picks the highest-priority pending, enabled source
// Assumes: purely combinational, evaluated every cycle
// Notes: level 0 never wins; on a tie the lowest index wins
`timescale 1ns/100ps
`include "itc_defs.svh"
module itc_arb
   import itc_pkg::*;
(
   input wire logic [`ITC_NSRC-1:0] req_i,
   input wire logic [`ITC_NSRC-1:0] en_i,
   input wire logic [`ITC_NSRC*`ITC_PRIO_W-1:0] prio_i,
   output logic win_vld_o,
   output itc_idx_t win_idx_o,
   output itc_prio_t win_prio_o
);
   // ==========================================================
   // priority scan
   // strict greater-than keeps the lower index on equal levels
   always_comb begin
      win_vld_o = 1'b0;
      win_idx_o = '0;
      win_prio_o = '0;
      for (int i = 0; i < `ITC_NSRC; i++) begin
         if (req_i[i] && en_i[i] &&
             (prio_i[i*`ITC_PRIO_W +: `ITC_PRIO_W] > win_prio_o)) begin
            win_vld_o = 1'b1;
            win_idx_o = itc_idx_t'(i);
            win_prio_o = prio_i[i*`ITC_PRIO_W +: `ITC_PRIO_W];
         end
      end
   end
endmodule

// *** itc_chan.sv ***
// Purpose: one transfer channel: count and control bits
// Assumes: svc_i is a one-cycle pulse per service
// Notes: a software write beats a service on the count in the same cycle; zero_o still pulses for that service
`timescale 1ns/100ps
`include "itc_defs.svh"
module itc_chan
   import itc_pkg::*;
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic wr_i,
   input wire logic [31:0] wdata_i,
   input wire logic svc_i,
   output itc_cnt_t cnt_o,
   output itc_ctl_t ctl_o,
   output logic zero_o
);
   itc_cnt_t cnt_reg; // transfers left
   itc_ctl_t ctl_reg; // width, increments, continuous
   logic zero_reg; // count just reached zero
   logic cont; // continuous mode, count frozen

   assign cont = ctl_reg[`ITC_CTL_CONT];
   assign cnt_o = cnt_reg;
   assign ctl_o = ctl_reg;
   assign zero_o = zero_reg;

   // ==========================================================
   // count and control
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_reg <= `ITC_RST_CNT;
         ctl_reg <= '0;
      end else if (wr_i) begin
         cnt_reg <= wdata_i[`ITC_CNT_W-1:0];
         ctl_reg <= wdata_i[`ITC_CTL_LO +: `ITC_CTL_W];
      end else if (svc_i && !cont && (cnt_reg != '0)) begin
         cnt_reg <= cnt_reg - `ITC_CNT_LAST;
      end
   end

   // zero event, one pulse for the service that used the last count
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         zero_reg <= 1'b0;
      end else begin
         zero_reg <= svc_i && !cont && (cnt_reg == `ITC_CNT_LAST);
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   AST_CNT_DEC: assert property (
      svc_i && !cont && !wr_i && (cnt_reg != '0)
      |=> cnt_reg == itc_cnt_t'($past(cnt_reg) - `ITC_CNT_LAST))
      else $error("count not decremented by one after service");
   AST_CNT_HOLD: assert property (
      svc_i && cont && !wr_i |=> $stable(cnt_reg))
      else $error("count changed in continuous mode");
endmodule

// *** itc_ctrl.sv ***
// Purpose: interrupt arbitration with one-cycle channel transfers
// Assumes: APB slave, 25 MHz clk_i; src_evt_i, cpu_* are same-clock logic
// Notes: addresses are within segment 0 (16 bits)
// Function
// - channel service moves one item, one cycle
// - pending sources re-prioritised every cycle
// - channel-selected winner with count left, or in continuous mode, launches a channel transfer
// - cpu service only above current cpu level
// - acknowledge: push machine state, then branch
// - eight channels, counts, control, pointer RAM
// - count decrements per service, not continuous mode
// - count reaching zero raises standard cpu interrupt
// - segment 0 moves, optional pointer increment
// - per-source flag, enable, priority; strict preemption
`timescale 1ns/100ps
`include "itc_defs.svh"
module itc_ctrl
   import itc_pkg::*;
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [`ITC_ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [`ITC_NSRC-1:0] src_evt_i,
   input wire logic [`ITC_PRIO_W-1:0] cpu_ilvl_i,
   input wire logic cpu_ack_i,
   output logic irq_req_o,
   output logic [`ITC_IDX_W-1:0] irq_vec_o,
   output logic [`ITC_PRIO_W-1:0] irq_prio_o,
   output logic state_push_o,
   output logic branch_o,
   output logic xfer_o,
   output logic xfer_word_o,
   output logic [`ITC_PTR_W-1:0] xfer_src_o,
   output logic [`ITC_PTR_W-1:0] xfer_dst_o,
   output logic sys_irq_o
);
   // ==========================================================
   // declarations
   itc_state_t state_reg; // sequencer
   logic [`ITC_ST_W-1:0] st_bits; // one-hot view of the state
   logic pready_reg; // high in every access phase
   logic [31:0] prdata_reg; // read data caught in setup
   logic pslverr_reg; // unmapped address
   logic [31:0] rd_data; // read mux
   logic rd_err; // read mux error
   logic wr_en; // write takes effect
   itc_idx_t a_idx; // register index within a group
   logic [`ITC_NSRC-1:0] req_vec; // request flags
   logic [`ITC_NSRC-1:0] en_vec; // enable flags
   logic [`ITC_NSRC-1:0] chsvc_vec; // channel service selected
   logic [`ITC_NSRC*`ITC_PRIO_W-1:0] prio_flat; // levels, packed
   itc_idx_t chnum_arr [`ITC_NSRC]; // channel of each source
   itc_cnt_t cnt_arr [`ITC_NCH]; // channel counts
   itc_ctl_t ctl_arr [`ITC_NCH]; // channel controls
   logic [`ITC_NCH-1:0] zero_vec; // count-reached-zero events
   itc_ptr_t srcp_mem [`ITC_NCH]; // source pointers
   itc_ptr_t dstp_mem [`ITC_NCH]; // destination pointers
   logic win_vld; // some source is eligible
   itc_idx_t win_idx; // winning source
   itc_prio_t win_prio; // its level
   itc_idx_t win_ch; // its channel
   logic chan_go; // winner served by its channel
   logic cpu_go; // winner served by the cpu
   logic go_chan; // transfer launched this cycle
   logic clr_on_xfer; // request dropped after the transfer
   itc_idx_t vec_reg; // source being offered to the cpu
   itc_prio_t prio_reg; // its level
   logic xfer_word_reg; // width of the move
   itc_ptr_t xfer_src_reg; // source address
   itc_ptr_t xfer_dst_reg; // destination address
   itc_idx_t xfer_idx_reg; // source that was served
   itc_idx_t xfer_ch_reg; // channel that was used
   logic xfer_last_reg; // move used the last count
   logic xfer_incs_reg; // source pointer stepped
   logic [`ITC_NCH-1:0] stat_reg; // sticky zero events
   logic [`ITC_NCH-1:0] stat_next;
   logic [`ITC_NCH-1:0] mask_reg; // interrupt mask
   logic [`ITC_NCH-1:0] mask_next;
   logic sys_irq_reg; // status interrupt

   // decodes a register group of eight words
   function automatic logic fn_hit(input logic [`ITC_ADDR_W-1:0] addr,
                                   input logic [`ITC_ADDR_W-1:0] base);
      fn_hit = (addr[`ITC_ADDR_W-1:5] == base[`ITC_ADDR_W-1:5]);
   endfunction

   // ==========================================================
   // outputs
   assign st_bits = state_reg;
   assign prdata_o = prdata_reg;
   assign pready_o = pready_reg;
   assign pslverr_o = pslverr_reg;
   assign irq_req_o = st_bits[`ITC_SB_REQ];
   assign state_push_o = st_bits[`ITC_SB_PUSH];
   assign branch_o = st_bits[`ITC_SB_BRANCH];
   assign xfer_o = st_bits[`ITC_SB_XFER];
   assign irq_vec_o = vec_reg;
   assign irq_prio_o = prio_reg;
   assign xfer_word_o = xfer_word_reg;
   assign xfer_src_o = xfer_src_reg;
   assign xfer_dst_o = xfer_dst_reg;
   assign sys_irq_o = sys_irq_reg;

   // ==========================================================
   // apb slave: zero wait states, data caught in the setup cycle
   assign wr_en = psel_i && penable_i && pwrite_i && pready_reg;
   assign a_idx = paddr_i[4:2];

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pready_reg <= 1'b0;
         prdata_reg <= '0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= psel_i && !penable_i;
         if (psel_i && !penable_i) begin
            prdata_reg <= pwrite_i ? 32'h0 : rd_data;
            pslverr_reg <= rd_err;
         end
      end
   end

   // read mux; reserved bits read as zero
   always_comb begin
      rd_data = 32'h0;
      rd_err = 1'b0;
      if (fn_hit(paddr_i, `ITC_OFS_SRC)) begin
         rd_data[`ITC_SC_REQ] = req_vec[a_idx];
         rd_data[`ITC_SC_EN] = en_vec[a_idx];
         rd_data[`ITC_SC_PRIO_LO +: `ITC_PRIO_W] =
            prio_flat[a_idx*`ITC_PRIO_W +: `ITC_PRIO_W];
         rd_data[`ITC_SC_CHSVC] = chsvc_vec[a_idx];
         rd_data[`ITC_SC_CH_LO +: `ITC_IDX_W] = chnum_arr[a_idx];
      end else if (fn_hit(paddr_i, `ITC_OFS_CNT)) begin
         rd_data[`ITC_CNT_W-1:0] = cnt_arr[a_idx];
         rd_data[`ITC_CTL_LO +: `ITC_CTL_W] = ctl_arr[a_idx];
      end else if (fn_hit(paddr_i, `ITC_OFS_SRCP)) begin
         rd_data[`ITC_PTR_W-1:0] = srcp_mem[a_idx];
      end else if (fn_hit(paddr_i, `ITC_OFS_DSTP)) begin
         rd_data[`ITC_PTR_W-1:0] = dstp_mem[a_idx];
      end else if (paddr_i == `ITC_OFS_STAT) begin
         rd_data[`ITC_NCH-1:0] = stat_reg;
      end else if (paddr_i == `ITC_OFS_MASK) begin
         rd_data[`ITC_NCH-1:0] = mask_reg;
      end else if (paddr_i == `ITC_OFS_STATE) begin
         rd_data[`ITC_ST_W-1:0] = st_bits;
         rd_data[`ITC_STV_LO +: `ITC_IDX_W] = vec_reg;
         rd_data[`ITC_STP_LO +: `ITC_PRIO_W] = prio_reg;
      end else begin
         rd_err = 1'b1; // unmapped word
      end
   end

   // ==========================================================
   // interrupt sources: flag, enable, level, service choice
   for (genvar i = 0; i < `ITC_NSRC; i++) begin : g_src
      logic sw_wr; // software writes this source's register
      logic hw_clr; // service consumed the request
      logic req_reg;
      logic en_reg;
      logic chsvc_reg;
      itc_prio_t prio_r_reg;
      itc_idx_t ch_reg;
      assign sw_wr = wr_en && fn_hit(paddr_i, `ITC_OFS_SRC) &&
                     (a_idx == itc_idx_t'(i));
      assign hw_clr = (go_chan && clr_on_xfer &&
                       (win_idx == itc_idx_t'(i))) ||
                      (irq_req_o && cpu_ack_i &&
                       (vec_reg == itc_idx_t'(i)));
      assign req_vec[i] = req_reg;
      assign en_vec[i] = en_reg;
      assign chsvc_vec[i] = chsvc_reg;
      assign prio_flat[i*`ITC_PRIO_W +: `ITC_PRIO_W] = prio_r_reg;
      assign chnum_arr[i] = ch_reg;

      // a new event beats both clears so it is never lost
      always_ff @(posedge clk_i or negedge resetn_i) begin
         if (!resetn_i) begin
            req_reg <= 1'b0;
         end else if (src_evt_i[i]) begin
            req_reg <= 1'b1;
         end else if (sw_wr) begin
            req_reg <= pwdata_i[`ITC_SC_REQ];
         end else if (hw_clr) begin
            req_reg <= 1'b0;
         end
      end

      // configuration fields, software only
      always_ff @(posedge clk_i or negedge resetn_i) begin
         if (!resetn_i) begin
            en_reg <= 1'b0;
            chsvc_reg <= 1'b0;
            prio_r_reg <= '0;
            ch_reg <= '0;
         end else if (sw_wr) begin
            en_reg <= pwdata_i[`ITC_SC_EN];
            chsvc_reg <= pwdata_i[`ITC_SC_CHSVC];
            prio_r_reg <= pwdata_i[`ITC_SC_PRIO_LO +: `ITC_PRIO_W];
            ch_reg <= pwdata_i[`ITC_SC_CH_LO +: `ITC_IDX_W];
         end
      end
   end

   // ==========================================================
   // arbitration and service decision, every cycle
   itc_arb u_arb (
      .req_i(req_vec),
      .en_i(en_vec),
      .prio_i(prio_flat),
      .win_vld_o(win_vld),
      .win_idx_o(win_idx),
      .win_prio_o(win_prio)
   );

   assign win_ch = chnum_arr[win_idx];
   // an exhausted count hands the request to the cpu instead
   assign chan_go = win_vld && chsvc_vec[win_idx] &&
                    ((cnt_arr[win_ch] != '0) ||
                     ctl_arr[win_ch][`ITC_CTL_CONT]);
   assign cpu_go = win_vld && !chan_go &&
                   (win_prio > cpu_ilvl_i);
   assign go_chan = (state_reg == ST_IDLE) && chan_go;
   // the last count leaves the flag set for the cpu
   assign clr_on_xfer = ctl_arr[win_ch][`ITC_CTL_CONT] ||
                        (cnt_arr[win_ch] != `ITC_CNT_LAST);

   // ==========================================================
   // eight channels
   for (genvar j = 0; j < `ITC_NCH; j++) begin : g_ch
      itc_chan u_chan (
         .clk_i(clk_i),
         .resetn_i(resetn_i),
         .wr_i(wr_en && fn_hit(paddr_i, `ITC_OFS_CNT) &&
               (a_idx == itc_idx_t'(j))),
         .wdata_i(pwdata_i),
         .svc_i(go_chan && (win_ch == itc_idx_t'(j))),
         .cnt_o(cnt_arr[j]),
         .ctl_o(ctl_arr[j]),
         .zero_o(zero_vec[j])
      );
   end

   // ==========================================================
   // pointer RAM; software write wins over the hardware step
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int k = 0; k < `ITC_NCH; k++) begin
            srcp_mem[k] <= `ITC_RST_PTR;
            dstp_mem[k] <= `ITC_RST_PTR;
         end
      end else begin
         if (go_chan && ctl_arr[win_ch][`ITC_CTL_INCS]) begin
            srcp_mem[win_ch] <= srcp_mem[win_ch] +
               (ctl_arr[win_ch][`ITC_CTL_WORD] ?
                `ITC_STEP_WORD : `ITC_STEP_BYTE);
         end
         if (go_chan && ctl_arr[win_ch][`ITC_CTL_INCD]) begin
            dstp_mem[win_ch] <= dstp_mem[win_ch] +
               (ctl_arr[win_ch][`ITC_CTL_WORD] ?
                `ITC_STEP_WORD : `ITC_STEP_BYTE);
         end
         if (wr_en && fn_hit(paddr_i, `ITC_OFS_SRCP)) begin
            srcp_mem[a_idx] <= pwdata_i[`ITC_PTR_W-1:0];
         end
         if (wr_en && fn_hit(paddr_i, `ITC_OFS_DSTP)) begin
            dstp_mem[a_idx] <= pwdata_i[`ITC_PTR_W-1:0];
         end
      end
   end

   // ==========================================================
   // sequencer; a transfer steals exactly one cycle
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg <= ST_IDLE;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (chan_go) begin
                  state_reg <= ST_XFER;
               end else if (cpu_go) begin
                  state_reg <= ST_REQ;
               end
            end
            ST_XFER: begin
               state_reg <= ST_IDLE;
            end
            ST_REQ: begin
               if (cpu_ack_i) begin
                  state_reg <= ST_PUSH;
               end else if (!cpu_go) begin
                  state_reg <= ST_IDLE; // withdrawn or outranked
               end
            end
            ST_PUSH: begin
               state_reg <= ST_BRANCH;
            end
            ST_BRANCH: begin
               state_reg <= ST_IDLE;
            end
            default: begin
               state_reg <= ST_IDLE; // recover from a broken code
            end
         endcase
      end
   end

   // offered vector follows the winner until the cpu takes it
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         vec_reg <= '0;
         prio_reg <= '0;
      end else if (cpu_go && ((state_reg == ST_IDLE) ||
                   ((state_reg == ST_REQ) && !cpu_ack_i))) begin
         vec_reg <= win_idx;
         prio_reg <= win_prio;
      end
   end

   // transfer descriptor; state save is skipped entirely
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         xfer_word_reg <= 1'b0;
         xfer_src_reg <= `ITC_RST_PTR;
         xfer_dst_reg <= `ITC_RST_PTR;
         xfer_idx_reg <= '0;
         xfer_ch_reg <= '0;
         xfer_last_reg <= 1'b0;
         xfer_incs_reg <= 1'b0;
      end else if (go_chan) begin
         xfer_word_reg <= ctl_arr[win_ch][`ITC_CTL_WORD];
         xfer_src_reg <= srcp_mem[win_ch];
         xfer_dst_reg <= dstp_mem[win_ch];
         xfer_idx_reg <= win_idx;
         xfer_ch_reg <= win_ch;
         xfer_last_reg <= !clr_on_xfer;
         xfer_incs_reg <= ctl_arr[win_ch][`ITC_CTL_INCS];
      end
   end

   // ==========================================================
   // status, mask and interrupt; set beats write-one-clear
   assign stat_next = zero_vec | (stat_reg &
      ~((wr_en && (paddr_i == `ITC_OFS_STAT)) ?
        pwdata_i[`ITC_NCH-1:0] : '0));
   assign mask_next = (wr_en && (paddr_i == `ITC_OFS_MASK)) ?
                      pwdata_i[`ITC_NCH-1:0] : mask_reg;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         stat_reg <= '0;
         mask_reg <= '0;
         sys_irq_reg <= 1'b0;
      end else begin
         stat_reg <= stat_next;
         mask_reg <= mask_next;
         sys_irq_reg <= |(stat_next & mask_next);
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   AST_XFER_ONE: assert property (xfer_o |=> !xfer_o)
      else $error("transfer lasted more than one cycle");
   AST_REEVAL: assert property (
      irq_req_o && !cpu_ack_i && !cpu_go |=> !irq_req_o)
      else $error("stale cpu request kept");
   AST_LAUNCH: assert property (
      (state_reg == ST_IDLE) && chan_go |=> xfer_o && !irq_req_o)
      else $error("channel service not launched");
   AST_CPU_LVL: assert property (
      irq_req_o |-> irq_prio_o > $past(cpu_ilvl_i))
      else $error("cpu request not above cpu level");
   AST_ACK_SEQ: assert property (
      irq_req_o && cpu_ack_i
      |=> state_push_o && !branch_o ##1 branch_o && $stable(irq_vec_o))
      else $error("push then branch not seen after acknowledge");
   AST_LAST_KEEP: assert property (
      xfer_o && xfer_last_reg && !$past(wr_en) |-> req_vec[xfer_idx_reg])
      else $error("request lost after final count");
   AST_MID_CLEAR: assert property (
      xfer_o && !xfer_last_reg && !$past(wr_en) && !$past(|src_evt_i)
      |-> !req_vec[xfer_idx_reg] && !irq_req_o)
      else $error("request not cleared after mid-count transfer");
   AST_PTR_STEP: assert property (
      xfer_o && xfer_incs_reg && !$past(wr_en)
      |-> srcp_mem[xfer_ch_reg] == xfer_src_o +
          (xfer_word_o ? `ITC_STEP_WORD : `ITC_STEP_BYTE))
      else $error("source pointer not stepped");
endmodule

// *** itc_cpu_model.sv ***
// Purpose: cpu core stand-in facing the interrupt transfer controller
// Assumes: same clock as the controller
// Notes: dly_i sets how slowly the cpu accepts an offered interrupt
`timescale 1ns/100ps
module itc_cpu_model (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [3:0] dly_i,
   input wire logic irq_req_i,
   input wire logic push_i,
   input wire logic branch_i,
   output logic ack_o,
   output logic [7:0] n_ok_o
);
   logic [3:0] wait_reg; // cycles the offer has stood so far
   logic push_reg; // push seen in the previous cycle
   // ==========================================================
   // accept an offer after dly_i cycles; one-cycle acknowledge
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wait_reg <= 4'h0;
         ack_o <= 1'b0;
      end else begin
         // only a standing offer is accepted
         ack_o <= irq_req_i && !ack_o && (wait_reg >= dly_i);
         wait_reg <= irq_req_i ? wait_reg + 4'h1 : 4'h0;
      end
   end
   // ==========================================================
   // count stack pushes followed at once by the branch
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         push_reg <= 1'b0;
         n_ok_o <= 8'h00;
      end else begin
         push_reg <= push_i;
         if (push_reg && branch_i) begin
            n_ok_o <= n_ok_o + 8'h01;
         end
      end
   end
endmodule

// *** interrupt_driven_transfer_ctrl_tb_top.sv ***
// Purpose: self-checking bench of the interrupt transfer controller
// Assumes: apb master tasks, cpu model as the far side
// Notes: waits are bounded; a run-out counts as a mismatch
`timescale 1ns/100ps
module interrupt_driven_transfer_ctrl_tb_top;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, irq_req, push, branch, xfer, xw, sys_irq, ack;
   logic [7:0] evt = 8'h00;
   logic [3:0] ilvl = 4'h0, dly = 4'h0, iprio;
   logic [2:0] ivec;
   logic [15:0] xs, xd;
   logic [7:0] n_ok;
   int num_errors = 0;
   int n_tests = 0;
   always #20 clk_i = ~clk_i;
   itc_ctrl DUT (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .src_evt_i(evt), .cpu_ilvl_i(ilvl),
      .cpu_ack_i(ack), .irq_req_o(irq_req), .irq_vec_o(ivec),
      .irq_prio_o(iprio), .state_push_o(push), .branch_o(branch),
      .xfer_o(xfer), .xfer_word_o(xw), .xfer_src_o(xs), .xfer_dst_o(xd),
      .sys_irq_o(sys_irq));
   itc_cpu_model CPU (.clk_i(clk_i), .resetn_i(resetn_i), .dly_i(dly),
      .irq_req_i(irq_req), .push_i(push), .branch_i(branch), .ack_o(ack),
      .n_ok_o(n_ok));
   // ==========================================================
   // one comparison; a mismatch is reported at once
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // apb transfer: setup, then access until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      do begin
         @(posedge clk_i);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) chk(32'h0, 32'h1);
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   // bounded wait for a design output to be high: 0 xfer, 1 irq_req,
   // 2 branch; a selector instead of a ref keeps free simulators happy
   task automatic wt(input int w);
      int k;
      logic s;
      k = 0;
      s = (w == 0) ? xfer : ((w == 1) ? irq_req : branch);
      while (s !== 1'b1 && k < 60) begin
         @(posedge clk_i);
         k++;
         s = (w == 0) ? xfer : ((w == 1) ? irq_req : branch);
      end
      if (k >= 60) chk(32'h0, 32'h1);
   endtask
   task ev(input int i);
      @(posedge clk_i);
      evt[i] <= 1'b1;
      @(posedge clk_i);
      evt <= 8'h00;
   endtask
   task end_sim;
      $display("errors=%0d comparisons=%0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      repeat (16) @(posedge clk_i);
      resetn_i <= 1'b1;
      rdc(8'h88, 32'h1); // idle after reset
      rdc(8'hfc, 32'h0);
      chk(err, 1'b1); // unmapped place refused
      apb(1'b1, 8'h00, 32'h56); // source 0: channel 0, level 5
      apb(1'b1, 8'h20, 32'h302); // two words, source steps
      apb(1'b1, 8'h40, 32'h1000);
      apb(1'b1, 8'h60, 32'h2000);
      apb(1'b1, 8'h84, 32'h1);
      ev(0);
      wt(0);
      chk(xw, 1'b1); // word move
      chk({xs, xd}, 32'h10002000);
      repeat (4) @(posedge clk_i);
      chk(irq_req, 1'b0);
      rdc(8'h00, 32'h56); // request flag dropped
      rdc(8'h20, 32'h301);
      rdc(8'h40, 32'h1002);
      ev(0);
      wt(0);
      chk(xs, 16'h1002);
      wt(2);
      // the cpu model counts the branch only at the edge that ends it
      @(posedge clk_i);
      chk({ivec, n_ok}, {3'h0, 8'h1});
      rdc(8'h80, 32'h1);
      chk(sys_irq, 1'b1);
      apb(1'b1, 8'h80, 32'h1);
      rdc(8'h80, 32'h0);
      chk(sys_irq, 1'b0);
      ilvl <= 4'h6;
      dly <= 4'h3;
      apb(1'b1, 8'h04, 32'h0e); // source 1: cpu service, level 3
      ev(1);
      repeat (6) @(posedge clk_i);
      chk(irq_req, 1'b0);
      ilvl <= 4'h2;
      wt(1);
      chk({ivec, iprio}, {3'h1, 4'h3});
      wt(2);
      @(posedge clk_i);
      chk(n_ok, 8'h2);
      apb(1'b1, 8'h28, 32'h805); // channel 2 continuous
      apb(1'b1, 8'h08, 32'h152);
      ev(2);
      wt(0);
      chk(xw, 1'b0); // byte move
      rdc(8'h28, 32'h805);
      rdc(8'h08, 32'h152); // continuous service drops the flag
      end_sim;
   end
endmodule
